// ==== verilog/acb_capture_buffer.sv ====
// Purpose: Capture buffer manager placing channel samples into shared memory.
// Assumes: Samples and tach pulses are synchronous to CLK_IN.
// Notes:   Change channel enables only while idle; regions are recomputed live.
`timescale 1ns/1ps
`default_nettype none
module acb_capture_buffer #(
  parameter int NCH = acb_pkg::ACB_NCH,
  parameter int CH_W = $clog2(acb_pkg::ACB_NCH),
  parameter int ADDR_W = acb_pkg::ACB_ADDR_W,
  parameter bit TACH_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // Configuration and control
  input wire acb_pkg::acb_mode_t MODE_IN,
  input wire acb_pkg::acb_trig_t TRIG_SRC_IN,
  input wire logic [NCH-1:0] CHAN_EN_IN,
  input wire logic [ADDR_W:0] POST_LEN_IN,
  input wire logic [7:0] MON_DECIM_IN,
  input wire logic START_IN,
  input wire logic STOP_IN,
  input wire logic TRIG_IN,
  input wire logic OVF_CLR_IN,
  // Tachometer
  input wire logic TACH_IN,
  input wire logic RPM_TRIG_EN_IN,
  input wire logic [acb_pkg::ACB_RPM_W-1:0] RPM_START_IN,
  input wire logic [acb_pkg::ACB_RPM_W-1:0] RPM_STOP_IN,
  input wire logic [acb_pkg::ACB_RPM_W-1:0] RPM_STEP_IN,
  // Sample input
  input wire logic SAMPLE_VALID_IN,
  input wire logic [CH_W-1:0] SAMPLE_CH_IN,
  input wire logic [acb_pkg::ACB_SAMPLE_W-1:0] SAMPLE_DATA_IN,
  // Host readout
  input wire logic HOST_RD_IN,
  input wire logic [CH_W-1:0] HOST_RD_CH_IN,
  output logic HOST_RD_VALID_OUT,
  output logic [acb_pkg::ACB_SAMPLE_W-1:0] HOST_RD_DATA_OUT,
  output logic [ADDR_W:0] HOST_FILL_OUT,
  // Local bus stream and host monitor copy
  output logic LBUS_VALID_OUT,
  output logic [CH_W-1:0] LBUS_CH_OUT,
  output logic [acb_pkg::ACB_SAMPLE_W-1:0] LBUS_DATA_OUT,
  output logic MON_VALID_OUT,
  // Block tags
  output logic TAG_VALID_OUT,
  output logic [CH_W-1:0] TAG_CH_OUT,
  output logic [acb_pkg::ACB_RPM_W-1:0] TAG_RPM_OUT,
  // Status
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic OVERFLOW_OUT,
  output logic [acb_pkg::ACB_RPM_W-1:0] RPM_OUT
);
  import acb_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************
  // Region geometry
  // ****************************************
  logic [CH_W:0] n_act;
  logic [ADDR_W:0] region_len;
  logic [CH_W:0] wr_rank;
  logic [CH_W:0] rd_rank;

  always_comb begin
    n_act = '0;
    wr_rank = '0;
    rd_rank = '0;
    for (int i = 0; i < NCH; i++) begin
      n_act = n_act + (CH_W+1)'(CHAN_EN_IN[i]);
      if (i < int'(SAMPLE_CH_IN)) wr_rank = wr_rank + (CH_W+1)'(CHAN_EN_IN[i]);
      if (i < int'(HOST_RD_CH_IN)) rd_rank = rd_rank + (CH_W+1)'(CHAN_EN_IN[i]);
    end
  end

  // Integer divide is slow but the inputs are static during a run
  assign region_len = (n_act == '0) ? (ADDR_W+1)'(DEPTH)
                                    : (ADDR_W+1)'(DEPTH / int'(n_act));

  // ****************************************
  // Control state
  // ****************************************
  acb_state_t state;
  acb_state_t next_state;
  logic trig;
  logic clr;
  logic storing;
  logic wrap_ok;
  logic [ADDR_W:0] post_left;
  logic [NCH-1:0] ch_full;
  logic [NCH-1:0] ch_store;
  logic [NCH-1:0] ch_wrap;
  logic [ADDR_W:0] cnt [NCH];
  logic [ADDR_W-1:0] wp [NCH];
  logic [ADDR_W-1:0] rp [NCH];
  logic any_store;
  logic blk_full;
  logic ovf_evt;
  logic rd_ok;
  acb_tach_if tif ();

  assign tif.en = RPM_TRIG_EN_IN;
  assign tif.start_rpm = RPM_START_IN;
  assign tif.stop_rpm = RPM_STOP_IN;
  assign tif.step_rpm = RPM_STEP_IN;

  acb_rpm_trigger #(.TACH_PRESENT(TACH_PRESENT)) u_rpm (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .tach_pulse_in(TACH_IN),
    .tif(tif)
  );

  assign trig = (TRIG_SRC_IN == ACB_TRIG_NOW) |
                ((TRIG_SRC_IN == ACB_TRIG_EXT) & TRIG_IN) |
                ((TRIG_SRC_IN == ACB_TRIG_RPM) & tif.trig);
  assign storing = (state == ACB_ST_RUN) | (state == ACB_ST_PRE) | (state == ACB_ST_POST);
  // Continuous mode drops oldest rather than pausing; circular keeps wrapping after
  // the trigger, so once the region is full each post sample drops the oldest pre-trigger sample
  assign wrap_ok = (state == ACB_ST_PRE) | (state == ACB_ST_POST) |
                   ((state == ACB_ST_RUN) & (MODE_IN == ACB_MODE_CONT));
  assign clr = (state == ACB_ST_IDLE || state == ACB_ST_DONE) & START_IN;
  assign any_store = |ch_store;
  // A full region only ends the run where samples may not wrap
  assign blk_full = ~wrap_ok & (|(CHAN_EN_IN & ch_full));
  assign ovf_evt = (state == ACB_ST_RUN) & (MODE_IN == ACB_MODE_FIFO) & SAMPLE_VALID_IN &
                   CHAN_EN_IN[SAMPLE_CH_IN] & ch_full[SAMPLE_CH_IN];
  assign rd_ok = HOST_RD_IN & (cnt[HOST_RD_CH_IN] != '0);

  always_comb begin
    next_state = state;
    case (state)
      ACB_ST_IDLE, ACB_ST_DONE: begin
        if (START_IN) next_state = (MODE_IN == ACB_MODE_CIRC) ? ACB_ST_PRE : ACB_ST_WAIT;
      end
      ACB_ST_WAIT: begin
        if (STOP_IN) next_state = ACB_ST_DONE;
        else if (trig) next_state = ACB_ST_RUN;
      end
      ACB_ST_RUN: begin
        if (STOP_IN || ovf_evt) next_state = ACB_ST_DONE;
        else if (MODE_IN == ACB_MODE_BLOCK && blk_full) next_state = ACB_ST_DONE;
      end
      ACB_ST_PRE: begin
        if (STOP_IN) next_state = ACB_ST_DONE;
        else if (trig) next_state = ACB_ST_POST;
      end
      ACB_ST_POST: begin
        if (STOP_IN || post_left == '0 || blk_full) next_state = ACB_ST_DONE;
      end
      default: next_state = ACB_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state <= ACB_ST_IDLE;
      post_left <= '0;
    end else begin
      state <= next_state;
      if (state == ACB_ST_PRE) post_left <= POST_LEN_IN;
      else if (state == ACB_ST_POST && any_store && post_left != '0) begin
        post_left <= post_left - (ADDR_W+1)'(1);
      end
    end
  end

  // Set wins over clear
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) OVERFLOW_OUT <= 1'b0;
    else OVERFLOW_OUT <= ovf_evt | (OVERFLOW_OUT & ~OVF_CLR_IN);
  end

  // ****************************************
  // Per-channel pointers
  // ****************************************
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic we;
    logic rd;
    logic drop;
    logic [ADDR_W-1:0] wp_inc;
    logic [ADDR_W-1:0] rp_inc;

    assign we = storing & SAMPLE_VALID_IN & CHAN_EN_IN[c] & (SAMPLE_CH_IN == CH_W'(c));
    assign rd = rd_ok & (HOST_RD_CH_IN == CH_W'(c));
    // A read in the same cycle frees a slot, so the channel is not full then
    assign ch_full[c] = (cnt[c] == region_len) & ~rd;
    assign drop = we & ch_full[c] & wrap_ok;
    assign ch_store[c] = we & (~ch_full[c] | wrap_ok) & ~ovf_evt;
    assign ch_wrap[c] = drop;
    assign wp_inc = (ADDR_W+1)'(wp[c]) + 1'b1 == region_len ? '0 : wp[c] + 1'b1;
    assign rp_inc = (ADDR_W+1)'(rp[c]) + 1'b1 == region_len ? '0 : rp[c] + 1'b1;

    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
        cnt[c] <= '0;
        wp[c] <= '0;
        rp[c] <= '0;
      end else if (clr) begin
        cnt[c] <= '0;
        wp[c] <= '0;
        rp[c] <= '0;
      end else begin
        if (ch_store[c]) wp[c] <= wp_inc;
        if (rd || drop) rp[c] <= rp_inc;
        if (ch_store[c] && !drop && !rd) cnt[c] <= cnt[c] + 1'b1;
        else if (rd && !ch_store[c]) cnt[c] <= cnt[c] - 1'b1;
      end
    end
  end

  // ****************************************
  // Sample memory
  // ****************************************
  logic [ACB_SAMPLE_W-1:0] mem [DEPTH];
  logic [ADDR_W-1:0] waddr;
  logic [ADDR_W-1:0] raddr;
  logic [ADDR_W-1:0] wp_sel;
  logic [7:0] mon_cnt;

  assign wp_sel = wp[SAMPLE_CH_IN];
  assign waddr = ADDR_W'(wr_rank * region_len) + wp_sel;
  assign raddr = ADDR_W'(rd_rank * region_len) + rp[HOST_RD_CH_IN];

  always_ff @(posedge CLK_IN) begin
    if (any_store) mem[waddr] <= SAMPLE_DATA_IN;
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      HOST_RD_VALID_OUT <= 1'b0;
      HOST_RD_DATA_OUT <= '0;
    end else begin
      HOST_RD_VALID_OUT <= rd_ok;
      if (rd_ok) HOST_RD_DATA_OUT <= mem[raddr];
    end
  end

  // ****************************************
  // Streams, tags and status
  // ****************************************
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      LBUS_VALID_OUT <= 1'b0;
      LBUS_CH_OUT <= '0;
      LBUS_DATA_OUT <= '0;
      MON_VALID_OUT <= 1'b0;
      mon_cnt <= '0;
    end else begin
      LBUS_VALID_OUT <= any_store;
      MON_VALID_OUT <= any_store & (mon_cnt == '0);
      if (any_store) begin
        LBUS_CH_OUT <= SAMPLE_CH_IN;
        LBUS_DATA_OUT <= SAMPLE_DATA_IN;
      end
      // Each run starts its monitor selection afresh
      if (clr) mon_cnt <= '0;
      else if (any_store) mon_cnt <= (mon_cnt >= MON_DECIM_IN) ? '0 : mon_cnt + 8'h1;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      TAG_VALID_OUT <= 1'b0;
      TAG_CH_OUT <= '0;
      TAG_RPM_OUT <= '0;
    end else begin
      // A block ends when the channel's write pointer wraps to its region start
      TAG_VALID_OUT <= any_store & ((ADDR_W+1)'(wp_sel) + 1'b1 == region_len);
      if (any_store) begin
        TAG_CH_OUT <= SAMPLE_CH_IN;
        TAG_RPM_OUT <= tif.rpm;
      end
    end
  end

  assign BUSY_OUT = storing | (state == ACB_ST_WAIT);
  assign DONE_OUT = (state == ACB_ST_DONE);
  assign HOST_FILL_OUT = cnt[HOST_RD_CH_IN];
  assign RPM_OUT = tif.rpm;

endmodule : acb_capture_buffer
`default_nettype wire

// ==== verilog/acb_pkg.sv ====
// Purpose: Shared constants and types of the acquisition capture buffer.
// Assumes: One 25 MHz system clock.
// Notes:   Memory size and sample size fix the default address width.
package acb_pkg;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam longint ACB_MEM_BYTES = 64'h2000000;
  localparam int ACB_BYTES_PER_SAMPLE = 2;
  localparam longint ACB_MEM_SAMPLES = ACB_MEM_BYTES / ACB_BYTES_PER_SAMPLE;
  localparam int ACB_ADDR_W = $clog2(ACB_MEM_SAMPLES);
  localparam int ACB_SAMPLE_W = 8 * ACB_BYTES_PER_SAMPLE;
  localparam int ACB_NCH = 16;
  localparam int ACB_RPM_W = 16;
  localparam int ACB_PER_W = 32;

  // ****************************************
  // Timing
  // ****************************************
  localparam int ACB_CLK_HZ = 25000000;
  localparam int ACB_SEC_PER_MIN = 60;
  localparam logic [ACB_PER_W-1:0] ACB_RPM_NUM = 32'(ACB_SEC_PER_MIN * ACB_CLK_HZ);

  // ****************************************
  // Modes, trigger sources, states
  // ****************************************
  typedef enum logic [1:0] {
    ACB_MODE_CONT = 2'h0,
    ACB_MODE_BLOCK = 2'h1,
    ACB_MODE_FIFO = 2'h2,
    ACB_MODE_CIRC = 2'h3
  } acb_mode_t;

  typedef enum logic [1:0] {
    ACB_TRIG_NOW = 2'h0,
    ACB_TRIG_EXT = 2'h1,
    ACB_TRIG_RPM = 2'h2
  } acb_trig_t;

  typedef enum logic [5:0] {
    ACB_ST_IDLE = 6'h01,
    ACB_ST_WAIT = 6'h02,
    ACB_ST_RUN = 6'h04,
    ACB_ST_PRE = 6'h08,
    ACB_ST_POST = 6'h10,
    ACB_ST_DONE = 6'h20
  } acb_state_t;

endpackage : acb_pkg

// ==== verilog/acb_tach_if.sv ====
// Purpose: Carries tachometer settings and results between buffer and meter.
// Assumes: Single clock domain.
// Notes:   No clocking block; plain signals only.
`timescale 1ns/1ps
`default_nettype none
interface acb_tach_if;
  import acb_pkg::*;
  logic en;
  logic [ACB_RPM_W-1:0] start_rpm;
  logic [ACB_RPM_W-1:0] stop_rpm;
  logic [ACB_RPM_W-1:0] step_rpm;
  logic [ACB_RPM_W-1:0] rpm;
  logic trig;

  modport meter (input en, input start_rpm, input stop_rpm, input step_rpm,
                 output rpm, output trig);
  modport user (output en, output start_rpm, output stop_rpm, output step_rpm,
                input rpm, input trig);
endinterface : acb_tach_if
`default_nettype wire

// ==== verilog/acb_rpm_trigger.sv ====
// Purpose: Measures shaft speed from tach pulses and raises RPM step triggers.
// Assumes: Tach pulse is one clock wide and synchronous.
// Notes:   Speed updates once per tach period.
`timescale 1ns/1ps
`default_nettype none
module acb_rpm_trigger #(
  parameter bit TACH_PRESENT = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tach_pulse_in,
  acb_tach_if.meter tif
);
  import acb_pkg::*;

  logic [ACB_PER_W-1:0] per_cnt;
  logic [ACB_PER_W-1:0] quot;
  logic [ACB_RPM_W-1:0] next_target;
  logic [ACB_RPM_W-1:0] target;
  logic armed;
  logic rpm_upd;
  logic dir_up;
  logic hit;
  logic past_stop;

  // Divider is wide but only has to settle once per tach period
  assign quot = (per_cnt == '0) ? '0 : ACB_RPM_NUM / per_cnt;
  assign dir_up = tif.stop_rpm >= tif.start_rpm;
  assign hit = armed & rpm_upd & (dir_up ? tif.rpm >= target : tif.rpm <= target);
  assign next_target = dir_up ? target + tif.step_rpm : target - tif.step_rpm;
  assign past_stop = dir_up ? (next_target > tif.stop_rpm) || (next_target < target)
                            : (next_target < tif.stop_rpm) || (next_target > target);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      per_cnt <= '0;
      tif.rpm <= '0;
      rpm_upd <= 1'b0;
    end else begin
      rpm_upd <= tach_pulse_in;
      if (tach_pulse_in) begin
        per_cnt <= 32'h1;
        tif.rpm <= (quot[ACB_PER_W-1:ACB_RPM_W] != '0) ? '1 : quot[ACB_RPM_W-1:0];
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      armed <= 1'b0;
      target <= '0;
      tif.trig <= 1'b0;
    end else begin
      tif.trig <= TACH_PRESENT & tif.en & hit;
      if (!tif.en) begin
        armed <= 1'b1;
        target <= tif.start_rpm;
      end else if (hit) begin
        target <= next_target;
        // A zero interval would otherwise fire on every revolution
        armed <= ~past_stop & (tif.step_rpm != '0);
      end
    end
  end

endmodule : acb_rpm_trigger
`default_nettype wire

// ==== sim/acb_capture_buffer_asserts.sv ====
// Purpose: Port-level checks of the capture buffer.
// Assumes: One clock; reset asynchronous, active high.
// Notes:   Bound to every buffer instance.
`timescale 1ns/1ps
`default_nettype none
module acb_capture_buffer_asserts #(
  parameter int NCH = 16,
  parameter int CH_W = 4,
  parameter int ADDR_W = 24
) (
  // Watched inputs
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire acb_pkg::acb_mode_t MODE_IN,
  input wire logic [NCH-1:0] CHAN_EN_IN,
  input wire logic START_IN,
  input wire logic OVF_CLR_IN,
  input wire logic TACH_IN,
  input wire logic SAMPLE_VALID_IN,
  input wire logic [CH_W-1:0] SAMPLE_CH_IN,
  input wire logic [15:0] SAMPLE_DATA_IN,
  input wire logic HOST_RD_IN,
  // Watched outputs
  input wire logic HOST_RD_VALID_OUT,
  input wire logic [ADDR_W:0] HOST_FILL_OUT,
  input wire logic LBUS_VALID_OUT,
  input wire logic [15:0] LBUS_DATA_OUT,
  input wire logic MON_VALID_OUT,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT,
  input wire logic OVERFLOW_OUT,
  input wire logic [15:0] RPM_OUT
);
  import acb_pkg::*;
  wire chan_on = CHAN_EN_IN[SAMPLE_CH_IN];
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence rd_req_s;
    HOST_RD_IN && HOST_FILL_OUT != '0;
  endsequence
  sequence rd_ans_s;
    HOST_RD_VALID_OUT;
  endsequence
  lbus_echo_a: assert property (
    LBUS_VALID_OUT |-> $past(SAMPLE_VALID_IN) && LBUS_DATA_OUT == $past(SAMPLE_DATA_IN))
    else $error("Stream word differs from sample");
  lbus_chan_a: assert property (LBUS_VALID_OUT |-> $past(chan_on))
    else $error("Disabled channel stored");
  mon_subset_a: assert property (MON_VALID_OUT |-> LBUS_VALID_OUT)
    else $error("Monitor word outside stream");
  rd_answer_a: assert property (rd_req_s |=> rd_ans_s)
    else $error("Read of filled channel unanswered");
  rd_cause_a: assert property (HOST_RD_VALID_OUT |-> $past(HOST_RD_IN))
    else $error("Read answer without request");
  start_busy_a: assert property (START_IN && !BUSY_OUT |=> BUSY_OUT)
    else $error("Start not taken");
  busy_done_a: assert property (!(BUSY_OUT && DONE_OUT))
    else $error("Busy and done together");
  ovf_sticky_a: assert property (
    OVERFLOW_OUT && !OVF_CLR_IN && !START_IN |=> OVERFLOW_OUT)
    else $error("Overflow flag dropped");
  ovf_stop_a: assert property (
    $rose(OVERFLOW_OUT) |-> DONE_OUT && MODE_IN == ACB_MODE_FIFO && $past(SAMPLE_VALID_IN))
    else $error("Overflow without stop");
  rpm_update_a: assert property ($changed(RPM_OUT) |-> $past(TACH_IN))
    else $error("Speed changed without tach pulse");
endmodule : acb_capture_buffer_asserts
bind acb_capture_buffer acb_capture_buffer_asserts #(
  .NCH(NCH), .CH_W(CH_W), .ADDR_W(ADDR_W)) u_asserts (.*);
`default_nettype wire

// ==== sim/acb_host_model.sv ====
// Purpose: Host reading samples out of the buffer.
// Assumes: Answer comes one cycle after the request edge.
// Notes:   Channel select stays on the last channel read.
`timescale 1ns/1ps
`default_nettype none
module acb_host_model #(
  parameter int CH_W = 4
) (
  // Clock
  input wire logic clk_in,
  // Read port
  output logic rd_out,
  output logic [CH_W-1:0] rd_ch_out,
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in
);
  initial begin
    rd_out = 1'b0;
    rd_ch_out = '0;
  end
  // One-cycle request; answer taken at the following edge
  task automatic read(input logic [CH_W-1:0] ch, output logic ok, output logic [15:0] d);
    rd_ch_out = ch;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    @(posedge clk_in);
    ok = rd_valid_in;
    d = rd_data_in;
    #1;
  endtask : read
endmodule : acb_host_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench of the capture buffer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Address width 8 so that regions fill in a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acb_pkg::*;
  localparam int AW = 8;
  logic CLK_IN, SYS_RST_IN, START_IN, STOP_IN, TRIG_IN, OVF_CLR_IN, TACH_IN;
  logic RPM_TRIG_EN_IN, SAMPLE_VALID_IN, HOST_RD_IN, HOST_RD_VALID_OUT, LBUS_VALID_OUT;
  logic MON_VALID_OUT, TAG_VALID_OUT, BUSY_OUT, DONE_OUT, OVERFLOW_OUT, ok;
  acb_mode_t MODE_IN;
  acb_trig_t TRIG_SRC_IN;
  logic [15:0] CHAN_EN_IN, RPM_START_IN, RPM_STOP_IN, RPM_STEP_IN, SAMPLE_DATA_IN;
  logic [15:0] HOST_RD_DATA_OUT, LBUS_DATA_OUT, TAG_RPM_OUT, RPM_OUT, rd;
  logic [AW:0] POST_LEN_IN, HOST_FILL_OUT;
  logic [7:0] MON_DECIM_IN;
  logic [3:0] SAMPLE_CH_IN, HOST_RD_CH_IN, LBUS_CH_OUT, TAG_CH_OUT;
  int n_mismatch = 0;
  int num_checks = 0;
  acb_capture_buffer #(.ADDR_W(AW)) DUT (.*);
  acb_host_model u_host (.clk_in(CLK_IN), .rd_out(HOST_RD_IN), .rd_ch_out(HOST_RD_CH_IN),
    .rd_valid_in(HOST_RD_VALID_OUT), .rd_data_in(HOST_RD_DATA_OUT));
  initial begin
    CLK_IN = 1'b0;
    forever #20 CLK_IN = ~CLK_IN;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick();
    @(posedge CLK_IN);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_done(input int n);
    for (int i = 0; i < n && DONE_OUT !== 1'b1; i++) begin
      tick();
    end
    if (DONE_OUT !== 1'b1) begin
      chk(DONE_OUT, 1'b1, "done timeout");
      end_of_test();
    end
  endtask : wait_done
  // Valid stays high between calls so back-to-back samples never glitch
  task automatic wr(input logic [3:0] ch, input logic [15:0] d, input logic ev, input logic em);
    SAMPLE_VALID_IN = 1'b1;
    SAMPLE_CH_IN = ch;
    SAMPLE_DATA_IN = d;
    tick();
    chk(LBUS_VALID_OUT, ev, "stream valid");
    if (ev) begin
      chk(LBUS_DATA_OUT, d, "stream data");
      chk(LBUS_CH_OUT, 16'(ch), "stream channel");
      chk(MON_VALID_OUT, em, "monitor valid");
    end
  endtask : wr
  task automatic run(input acb_mode_t m, input acb_trig_t s, input logic [15:0] en);
    MODE_IN = m;
    TRIG_SRC_IN = s;
    CHAN_EN_IN = en;
    START_IN = 1'b1;
    tick();
    START_IN = 1'b0;
    chk(BUSY_OUT, 1'b1, "busy after start");
    tick();
  endtask : run
  task automatic stop();
    STOP_IN = 1'b1;
    tick();
    STOP_IN = 1'b0;
    wait_done(3);
  endtask : stop
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_tach();
    for (int i = 0; i < 3; i++) begin
      TACH_IN = 1'b1;
      tick();
      TACH_IN = 1'b0;
      repeat (99) tick();
    end
    chk(RPM_OUT, 16'hffff, "saturated speed");
    run(ACB_MODE_BLOCK, ACB_TRIG_RPM, 16'h0001);
    RPM_TRIG_EN_IN = 1'b1;
    wr(4'h0, 16'h0bad, 1'b0, 1'b0);
    SAMPLE_VALID_IN = 1'b0;
    TACH_IN = 1'b1;
    tick();
    TACH_IN = 1'b0;
    repeat (4) tick();
    wr(4'h0, 16'h0001, 1'b1, 1'b1);
    SAMPLE_VALID_IN = 1'b0;
    RPM_TRIG_EN_IN = 1'b0;
    stop();
  endtask : t_tach
  task automatic t_cont();
    MON_DECIM_IN = 8'h01;
    run(ACB_MODE_CONT, ACB_TRIG_NOW, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 16'ha000 + 16'(i), 1'b1, i[0] == 1'b0);
    end
    SAMPLE_VALID_IN = 1'b0;
    MON_DECIM_IN = 8'h00;
    u_host.read(4'h0, ok, rd);
    chk(ok, 1'b1, "read while running");
    chk(rd, 16'ha000, "oldest sample");
    chk(BUSY_OUT, 1'b1, "run not paused");
    stop();
  endtask : t_cont
  task automatic t_fifo();
    run(ACB_MODE_FIFO, ACB_TRIG_NOW, 16'h0003);
    for (int i = 0; i < 128; i++) begin
      wr(4'h0, 16'(i), 1'b1, 1'b1);
    end
    chk(HOST_FILL_OUT, 16'h0080, "half memory region");
    chk(OVERFLOW_OUT, 1'b0, "no overflow yet");
    wr(4'h0, 16'h0bad, 1'b0, 1'b0);
    SAMPLE_VALID_IN = 1'b0;
    chk(OVERFLOW_OUT, 1'b1, "overflow flag");
    chk(DONE_OUT, 1'b1, "stopped on overflow");
    u_host.read(4'h0, ok, rd);
    chk(ok, 1'b1, "read after overflow");
    chk(rd, 16'h0000, "kept sample");
    chk(HOST_FILL_OUT, 16'h007f, "fill after read");
    OVF_CLR_IN = 1'b1;
    tick();
    OVF_CLR_IN = 1'b0;
    chk(OVERFLOW_OUT, 1'b0, "overflow cleared");
  endtask : t_fifo
  task automatic t_block();
    run(ACB_MODE_BLOCK, ACB_TRIG_NOW, 16'h000f);
    for (int i = 0; i < 64; i++) begin
      wr(4'h1, 16'h0100 + 16'(i), 1'b1, 1'b1);
    end
    SAMPLE_VALID_IN = 1'b0;
    chk(TAG_VALID_OUT, 1'b1, "block tag");
    chk(TAG_CH_OUT, 16'h1, "tag channel");
    chk(TAG_RPM_OUT, 16'hffff, "tag speed");
    wait_done(4);
    wr(4'h1, 16'h0bad, 1'b0, 1'b0);
    SAMPLE_VALID_IN = 1'b0;
    u_host.read(4'h1, ok, rd);
    chk(rd, 16'h0100, "block first sample");
    chk(HOST_FILL_OUT, 16'h003f, "quarter region");
  endtask : t_block
  task automatic t_circ();
    run(ACB_MODE_CIRC, ACB_TRIG_EXT, 16'h0001);
    for (int i = 0; i < 300; i++) begin
      wr(4'h0, 16'(i), 1'b1, 1'b1);
    end
    SAMPLE_VALID_IN = 1'b0;
    chk(DONE_OUT, 1'b0, "wrapping without end");
    TRIG_IN = 1'b1;
    tick();
    TRIG_IN = 1'b0;
    tick();
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 16'h0200 + 16'(i), 1'b1, 1'b1);
    end
    SAMPLE_VALID_IN = 1'b0;
    wait_done(3);
    // Post samples pushed out four more of the oldest: sample 48 is now first
    u_host.read(4'h0, ok, rd);
    chk(ok, 1'b1, "read after circular run");
    chk(rd, 16'h0030, "oldest kept pre-trigger sample");
    chk(HOST_FILL_OUT, 16'h00ff, "circular fill after read");
  endtask : t_circ
  initial begin
    SYS_RST_IN = 1'b1;
    MODE_IN = ACB_MODE_CONT;
    TRIG_SRC_IN = ACB_TRIG_NOW;
    CHAN_EN_IN = 16'h0001;
    POST_LEN_IN = 9'h004;
    MON_DECIM_IN = 8'h00;
    START_IN = 1'b0;
    STOP_IN = 1'b0;
    TRIG_IN = 1'b0;
    OVF_CLR_IN = 1'b0;
    TACH_IN = 1'b0;
    RPM_TRIG_EN_IN = 1'b0;
    RPM_START_IN = 16'h0100;
    RPM_STOP_IN = 16'hffff;
    RPM_STEP_IN = 16'h0100;
    SAMPLE_VALID_IN = 1'b0;
    SAMPLE_CH_IN = 4'h0;
    SAMPLE_DATA_IN = 16'h0000;
    repeat (5) @(posedge CLK_IN);
    chk(BUSY_OUT, 1'b0, "busy in reset");
    chk(OVERFLOW_OUT, 1'b0, "overflow in reset");
    #1;
    SYS_RST_IN = 1'b0;
    t_tach();
    t_cont();
    t_fifo();
    t_block();
    t_circ();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
